// file: design/pibc_ctrl.sv
// Purpose: Parameter default restore and flash backup sequencer
// Assumes: Flash engine acks each word command, reporting failure
// Notes:   Power-up load runs first; requests wait until it ends

`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Init starts when host writes 1
// - Backup starts when host writes 1
// - Device clears init word when done
// - Device clears save word when done
// - Init refused with 111 if host ready
// - Failed write past 100000 gives 801
// - Over 25 session writes gives 805
// - Backup copies parameters, positions, block data
// - Power-up loads flash back into buffer
// - Init also restores flash copy
module pibc_ctrl (
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_b_i,
    input  wire logic                   ce_i,
    input  wire pibc_pkg::pibc_bm_req_t bm_req_i,
    output logic [15:0]                 bm_rdata_o,
    input  wire logic                   host_ready_output_i,
    input  wire logic                   err_clear_i,
    output logic                        mem_req_o,
    output pibc_pkg::pibc_mem_cmd_t     mem_cmd_o,
    input  wire logic                   mem_ack_i,
    input  wire logic                   mem_fail_i,
    input  wire logic [19:0]            flash_life_count_i,
    output logic                        busy_o,
    output logic [15:0]                 warn_code_o,
    output logic [15:0]                 err_code_o,
    output logic [4:0]                  flash_write_count_monitor_o
);

    // ************************************************************
    // Declarations
    // ************************************************************
    pibc_pkg::pibc_state_t st_q;
    pibc_pkg::pibc_op_t    op_q;
    pibc_pkg::pibc_area_t  area_q;
    logic [15:0]           init_req_q;
    logic [15:0]           save_req_q;
    logic [15:0]           rdata_q;
    logic [15:0]           warn_q;
    logic [15:0]           err_q;
    logic [4:0]            session_q;
    logic [9:0]            walk_cnt;
    logic                  walk_last;
    logic [9:0]            area_limit;
    logic [12:0]           area_base;
    logic                  init_pend;
    logic                  save_pend;
    logic                  start_init;
    logic                  start_save;
    logic                  refuse_init;
    logic                  refuse_save;
    logic                  xfer_ok;
    logic                  xfer_fail;
    logic                  area_done;
    logic                  all_done;
    logic                  init_busy;
    logic                  save_busy;
    logic                  wr_init;
    logic                  wr_save;

    // ************************************************************
    // Request decode
    // ************************************************************
    assign init_pend = (init_req_q == pibc_pkg::REQ_ON);
    assign save_pend = (save_req_q == pibc_pkg::REQ_ON);

    // Init takes precedence when both words are set together
    assign start_init  = (st_q == pibc_pkg::ST_IDLE) && init_pend
                         && !host_ready_output_i;
    assign refuse_init = (st_q == pibc_pkg::ST_IDLE) && init_pend
                         && host_ready_output_i;
    assign start_save  = (st_q == pibc_pkg::ST_IDLE) && !init_pend
                         && save_pend
                         && (session_q != pibc_pkg::SESSION_MAX);
    assign refuse_save = (st_q == pibc_pkg::ST_IDLE) && !init_pend
                         && save_pend
                         && (session_q == pibc_pkg::SESSION_MAX);

    assign xfer_ok   = (st_q == pibc_pkg::ST_XFER) && mem_ack_i
                       && !mem_fail_i;
    assign xfer_fail = (st_q == pibc_pkg::ST_XFER) && mem_ack_i
                       && mem_fail_i;
    assign area_done = xfer_ok && walk_last;
    assign all_done  = area_done && (area_q == pibc_pkg::AREA_BLK);

    assign init_busy = (st_q != pibc_pkg::ST_IDLE)
                       && (op_q == pibc_pkg::OP_DEFAULT);
    assign save_busy = (st_q != pibc_pkg::ST_IDLE)
                       && (op_q == pibc_pkg::OP_BACKUP);

    // Host writes land only while that word is not in use
    assign wr_init = bm_req_i.wr && !init_busy
                     && (bm_req_i.addr == pibc_pkg::ADDR_INIT_REQ);
    assign wr_save = bm_req_i.wr && !save_busy
                     && (bm_req_i.addr == pibc_pkg::ADDR_SAVE_REQ);

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Reset release starts the flash-to-buffer load
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q   <= pibc_pkg::ST_XFER;
            op_q   <= pibc_pkg::OP_LOAD;
            area_q <= pibc_pkg::AREA_PAR;
        end else if (ce_i) begin
            unique case (st_q)
                pibc_pkg::ST_IDLE: begin
                    area_q <= pibc_pkg::AREA_PAR;
                    if (start_init) begin
                        op_q <= pibc_pkg::OP_DEFAULT;
                        st_q <= pibc_pkg::ST_XFER;
                    end else if (start_save) begin
                        op_q <= pibc_pkg::OP_BACKUP;
                        st_q <= pibc_pkg::ST_XFER;
                    end
                end
                pibc_pkg::ST_XFER: begin
                    if (xfer_fail || all_done) begin
                        st_q <= pibc_pkg::ST_FINISH;
                    end else if (area_done) begin
                        // Parameters, then positions, then block data
                        if (area_q == pibc_pkg::AREA_PAR) begin
                            area_q <= pibc_pkg::AREA_POS;
                        end else begin
                            area_q <= pibc_pkg::AREA_BLK;
                        end
                    end
                end
                pibc_pkg::ST_FINISH: begin
                    st_q <= pibc_pkg::ST_IDLE;
                    op_q <= pibc_pkg::OP_NONE;
                end
                // Unused state code falls back to idle
                default: begin
                    st_q <= pibc_pkg::ST_IDLE;
                    op_q <= pibc_pkg::OP_NONE;
                end
            endcase
        end
    end

    // ************************************************************
    // Area walker
    // ************************************************************
    // Bounds and base of the area being walked
    always_comb begin
        area_limit = pibc_pkg::PAR_LAST;
        area_base  = pibc_pkg::PAR_BASE;
        unique case (area_q)
            pibc_pkg::AREA_POS: begin
                area_limit = pibc_pkg::POS_LAST;
                area_base  = pibc_pkg::POS_BASE;
            end
            pibc_pkg::AREA_BLK: begin
                area_limit = pibc_pkg::BLK_LAST;
                area_base  = pibc_pkg::BLK_BASE;
            end
            default: begin
                area_limit = pibc_pkg::PAR_LAST;
                area_base  = pibc_pkg::PAR_BASE;
            end
        endcase
    end

    pibc_step_ctr #(
        .W          (pibc_pkg::IDX_W)
    ) u_walk (
        .clk_sys_i  (clk_sys_i),
        .rst_b_i    (rst_b_i),
        .ce_i       (ce_i),
        .clear_i    (start_init || start_save || area_done),
        .step_i     (xfer_ok),
        .limit_i    (area_limit),
        .count_o    (walk_cnt),
        .last_o     (walk_last)
    );

    // ************************************************************
    // Request words
    // ************************************************************
    // Refusal and completion both clear the word
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            init_req_q <= pibc_pkg::REQ_OFF;
        end else if (ce_i) begin
            if (refuse_init) begin
                init_req_q <= pibc_pkg::REQ_OFF;
            end else if ((st_q == pibc_pkg::ST_FINISH)
                         && (op_q == pibc_pkg::OP_DEFAULT)) begin
                init_req_q <= pibc_pkg::REQ_OFF;
            end else if (wr_init) begin
                init_req_q <= bm_req_i.wdata;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            save_req_q <= pibc_pkg::REQ_OFF;
        end else if (ce_i) begin
            if (refuse_save) begin
                save_req_q <= pibc_pkg::REQ_OFF;
            end else if ((st_q == pibc_pkg::ST_FINISH)
                         && (op_q == pibc_pkg::OP_BACKUP)) begin
                save_req_q <= pibc_pkg::REQ_OFF;
            end else if (wr_save) begin
                save_req_q <= bm_req_i.wdata;
            end
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    // Data holds until the next read
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= pibc_pkg::RD_UNMAPPED;
        end else if (ce_i && bm_req_i.rd) begin
            unique case (bm_req_i.addr)
                pibc_pkg::ADDR_INIT_REQ: rdata_q <= init_req_q;
                pibc_pkg::ADDR_SAVE_REQ: rdata_q <= save_req_q;
                default:                 rdata_q <= pibc_pkg::RD_UNMAPPED;
            endcase
        end
    end

    // ************************************************************
    // Session write count
    // ************************************************************
    // Only a reset brings the count, and so error 805, back
    // Counted at start, so failed backups count too
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            session_q <= pibc_pkg::SESSION_RST;
        end else if (ce_i && start_save) begin
            session_q <= session_q + 5'h01;
        end
    end

    // ************************************************************
    // Warning and error codes
    // ************************************************************
    // Set wins over a clear in the same cycle
    // An 801 never overwrites a standing 805
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            warn_q <= pibc_pkg::CODE_NONE;
        end else if (ce_i) begin
            if (refuse_init) begin
                warn_q <= pibc_pkg::WARN_HOST_READY;
            end else if (err_clear_i) begin
                warn_q <= pibc_pkg::CODE_NONE;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            err_q <= pibc_pkg::CODE_NONE;
        end else if (ce_i) begin
            if (refuse_save) begin
                err_q <= pibc_pkg::ERR_WRITE_NUM;
            end else if (xfer_fail && (op_q != pibc_pkg::OP_LOAD)
                         && (err_q != pibc_pkg::ERR_WRITE_NUM)
                         && (flash_life_count_i > pibc_pkg::LIFE_MAX)) begin
                err_q <= pibc_pkg::ERR_FLASH_WRITE;
            end else if (err_clear_i
                         && (err_q != pibc_pkg::ERR_WRITE_NUM)) begin
                err_q <= pibc_pkg::CODE_NONE;
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Entry is area base plus walk index
    assign mem_req_o        = (st_q == pibc_pkg::ST_XFER);
    assign mem_cmd_o.op     = op_q;
    assign mem_cmd_o.area   = area_q;
    assign mem_cmd_o.entry  = area_base + {3'b000, walk_cnt};
    assign bm_rdata_o       = rdata_q;
    assign busy_o           = (st_q != pibc_pkg::ST_IDLE);
    assign warn_code_o      = warn_q;
    assign err_code_o       = err_q;
    assign flash_write_count_monitor_o = session_q;

endmodule : pibc_ctrl

`default_nettype wire

// file: design/pibc_pkg.sv
// Purpose: Shared constants and types for the init and backup controller
// Assumes: Buffer memory words are 16 bits wide
// Notes:   Entry numbers are the printed positioning and block numbers

package pibc_pkg;

    // ************************************************************
    // Buffer memory map
    // ************************************************************
    localparam logic [15:0] ADDR_SAVE_REQ = 16'h076C;
    localparam logic [15:0] ADDR_INIT_REQ = 16'h076D;
    localparam logic [15:0] REQ_ON        = 16'h0001;
    localparam logic [15:0] REQ_OFF       = 16'h0000;
    localparam logic [15:0] RD_UNMAPPED   = 16'h0000;

    // ************************************************************
    // Warning and error codes
    // ************************************************************
    localparam logic [15:0] CODE_NONE       = 16'h0000;
    localparam logic [15:0] WARN_HOST_READY = 16'h006F;
    localparam logic [15:0] ERR_FLASH_WRITE = 16'h0321;
    localparam logic [15:0] ERR_WRITE_NUM   = 16'h0325;

    // ************************************************************
    // Data areas and limits
    // ************************************************************
    localparam int          IDX_W       = 10;
    localparam int          ENTRY_W     = 13;
    localparam logic [9:0]  PAR_LAST    = 10'h039;
    localparam logic [9:0]  POS_LAST    = 10'h257;
    localparam logic [9:0]  BLK_LAST    = 10'h004;
    localparam logic [12:0] PAR_BASE    = 13'h0000;
    localparam logic [12:0] POS_BASE    = 13'h0001;
    localparam logic [12:0] BLK_BASE    = 13'h1B58;
    localparam logic [4:0]  SESSION_MAX = 5'h19;
    localparam logic [4:0]  SESSION_RST = 5'h00;
    localparam logic [19:0] LIFE_MAX    = 20'h1_86A0;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        OP_NONE,
        OP_DEFAULT,
        OP_BACKUP,
        OP_LOAD
    } pibc_op_t;

    typedef enum logic [1:0] {
        AREA_PAR,
        AREA_POS,
        AREA_BLK
    } pibc_area_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_XFER,
        ST_FINISH
    } pibc_state_t;

    typedef struct packed {
        pibc_op_t         op;
        pibc_area_t       area;
        logic [12:0]      entry;
    } pibc_mem_cmd_t;

    typedef struct packed {
        logic             wr;
        logic             rd;
        logic [15:0]      addr;
        logic [15:0]      wdata;
    } pibc_bm_req_t;

endpackage : pibc_pkg

// file: design/pibc_step_ctr.sv
// Purpose: Word counter that walks one data area
// Assumes: Clear has priority over step
// Notes:   Last flag compares against the area's final index

`timescale 1ns/1ps
`default_nettype none

module pibc_step_ctr #(
    parameter int W = 10
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rst_b_i,
    input  wire logic         ce_i,
    input  wire logic         clear_i,
    input  wire logic         step_i,
    input  wire logic [W-1:0] limit_i,
    output logic      [W-1:0] count_o,
    output logic              last_o
);

    logic [W-1:0] count_q;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_q <= '0;
        end else if (ce_i) begin
            if (clear_i) begin
                count_q <= '0;
            end else if (step_i) begin
                count_q <= count_q + W'(1);
            end
        end
    end

    assign count_o = count_q;
    assign last_o  = (count_q == limit_i);

endmodule : pibc_step_ctr

`default_nettype wire

// file: tb/pibc_ctrl_chk.sv
// Purpose: Port assertions for the init and backup controller
// Assumes: Bound to pibc_ctrl, one clock domain
// Notes:   Host word writes seen only at the bus port
`timescale 1ns/1ps
`default_nettype none
module pibc_ctrl_chk (
    input wire logic                    clk_sys_i,
    input wire logic                    rst_b_i,
    input wire logic                    ce_i,
    input wire pibc_pkg::pibc_bm_req_t  bm_req_i,
    input wire logic                    host_ready_output_i,
    input wire logic                    mem_req_o,
    input wire pibc_pkg::pibc_mem_cmd_t mem_cmd_o,
    input wire logic                    mem_ack_i,
    input wire logic                    mem_fail_i,
    input wire logic [19:0]             flash_life_count_i,
    input wire logic                    busy_o,
    input wire logic [15:0]             err_code_o,
    input wire logic [15:0]             warn_code_o,
    input wire logic [4:0]              flash_write_count_monitor_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    logic go;
    logic wr1;
    logic [4:0] cnt;
    assign go  = ce_i && !busy_o;
    assign wr1 = go && bm_req_i.wr && bm_req_i.wdata == pibc_pkg::REQ_ON;
    assign cnt = flash_write_count_monitor_o;
    a_init_start: assert property (
        wr1 && bm_req_i.addr == pibc_pkg::ADDR_INIT_REQ
        ##1 go && !host_ready_output_i
        |=> busy_o && mem_cmd_o.op == pibc_pkg::OP_DEFAULT)
        else $error("init did not start");
    a_init_refuse: assert property (
        wr1 && bm_req_i.addr == pibc_pkg::ADDR_INIT_REQ
        ##1 go && host_ready_output_i
        |=> !busy_o && warn_code_o == pibc_pkg::WARN_HOST_READY)
        else $error("init not refused");
    a_save_start: assert property (
        wr1 && bm_req_i.addr == pibc_pkg::ADDR_SAVE_REQ
        && cnt < pibc_pkg::SESSION_MAX ##1 go
        |=> busy_o && mem_cmd_o.op inside
            {pibc_pkg::OP_BACKUP, pibc_pkg::OP_DEFAULT})
        else $error("backup did not start");
    a_save_limit: assert property (
        wr1 && bm_req_i.addr == pibc_pkg::ADDR_SAVE_REQ
        && cnt == pibc_pkg::SESSION_MAX ##1 go
        |=> !busy_o && err_code_o == pibc_pkg::ERR_WRITE_NUM)
        else $error("session limit missed");
    a_count_step: assert property (
        $rose(mem_req_o) && mem_cmd_o.op == pibc_pkg::OP_BACKUP
        |-> cnt == $past(cnt) + 5'h01)
        else $error("write count not stepped");
    a_err_sticky: assert property (
        err_code_o == pibc_pkg::ERR_WRITE_NUM
        |=> err_code_o == pibc_pkg::ERR_WRITE_NUM)
        else $error("count error lost");
    a_fail_code: assert property (
        ce_i && mem_req_o && mem_ack_i && mem_fail_i
        && flash_life_count_i > pibc_pkg::LIFE_MAX
        && mem_cmd_o.op != pibc_pkg::OP_LOAD
        && err_code_o != pibc_pkg::ERR_WRITE_NUM
        |-> ##[1:2] err_code_o == pibc_pkg::ERR_FLASH_WRITE)
        else $error("flash write error missed");
    a_cmd_hold: assert property (
        ce_i && mem_req_o && !mem_ack_i
        |=> mem_req_o && $stable(mem_cmd_o))
        else $error("word command dropped");
    a_last_word: assert property (
        ce_i && mem_req_o && mem_ack_i
        && mem_cmd_o.area == pibc_pkg::AREA_BLK
        && mem_cmd_o.entry == pibc_pkg::BLK_BASE + 13'(pibc_pkg::BLK_LAST)
        |=> !mem_req_o ##1 !busy_o)
        else $error("no finish after last word");
endmodule : pibc_ctrl_chk
`default_nettype wire

// file: tb/pibc_flash_model.sv
// Purpose: Flash engine model acking word commands
// Assumes: One ack per word, fail qualifies ack
// Notes:   Slow mode acks every other cycle
`timescale 1ns/1ps
`default_nettype none
module pibc_flash_model (
    input  wire logic                    clk_sys_i,
    input  wire logic                    rst_b_i,
    input  wire logic                    slow_i,
    input  wire logic                    fail_i,
    input  wire logic                    mem_req_i,
    input  wire pibc_pkg::pibc_mem_cmd_t mem_cmd_i,
    output logic                         mem_ack_o,
    output logic                         mem_fail_o,
    output logic [15:0]                  ack_cnt_o,
    output pibc_pkg::pibc_op_t           last_op_o
);
    // Fail line meaningless outside an ack
    assign mem_fail_o = mem_ack_o ? fail_i : !fail_i;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mem_ack_o <= 1'b0;
            ack_cnt_o <= 16'h0000;
            last_op_o <= pibc_pkg::OP_NONE;
        end else begin
            mem_ack_o <= mem_req_i && !(slow_i && mem_ack_o);
            if (mem_ack_o && mem_req_i) begin
                ack_cnt_o <= ack_cnt_o + 16'h0001;
                last_op_o <= mem_cmd_i.op;
            end
        end
    end
endmodule : pibc_flash_model
`default_nettype wire

// file: tb/tb_param_init_and_backup_ctrl.sv
// Purpose: Self-checking bench for the init and backup controller
// Assumes: Flash model answers every word command
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
    mismatches++; $display("wrong value at %0t: got %h exp %h", \
    $time, g, e); end end
module tb_param_init_and_backup_ctrl;
    logic                    clk_sys_i, rst_b_i, host_rdy, err_clr, ce;
    logic                    slow, fail, mem_req, mem_ack, mem_fail, busy;
    logic [19:0]             life;
    logic [15:0]             rdata, warn, err, acks, a0, d;
    logic [4:0]              cnt;
    pibc_pkg::pibc_bm_req_t  bm_req;
    pibc_pkg::pibc_mem_cmd_t cmd;
    pibc_pkg::pibc_op_t      last_op;
    int                      mismatches, checks_done, cyc;
    pibc_ctrl u_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce),
        .bm_req_i(bm_req), .bm_rdata_o(rdata), .host_ready_output_i(host_rdy),
        .err_clear_i(err_clr), .mem_req_o(mem_req), .mem_cmd_o(cmd),
        .mem_ack_i(mem_ack), .mem_fail_i(mem_fail), .flash_life_count_i(life),
        .busy_o(busy), .warn_code_o(warn), .err_code_o(err),
        .flash_write_count_monitor_o(cnt));
    pibc_flash_model u_flash (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .slow_i(slow), .fail_i(fail), .mem_req_i(mem_req), .mem_cmd_i(cmd),
        .mem_ack_o(mem_ack), .mem_fail_o(mem_fail), .ack_cnt_o(acks),
        .last_op_o(last_op));
    // ************************************************************
    // Clock, timeout and bus tasks
    // ************************************************************
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic final_report();
        $display("mismatches %0d checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(negedge clk_sys_i);
        bm_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(negedge clk_sys_i);
        bm_req.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [15:0] v);
        @(negedge clk_sys_i);
        bm_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge clk_sys_i);
        bm_req.rd = 1'b0;
        v = rdata;
    endtask : rd
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (2) @(negedge clk_sys_i);
        while (busy !== 1'b0 && n < 3000) begin
            @(negedge clk_sys_i);
            n++;
        end
        `CHK(busy, 1'b0)
    endtask : wait_idle
    task automatic pulse_clear();
        err_clr = 1'b1;
        @(negedge clk_sys_i);
        err_clr = 1'b0;
        @(negedge clk_sys_i);
    endtask : pulse_clear
    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        {rst_b_i, host_rdy, err_clr, slow, fail} = 5'b0_0000;
        bm_req = '0;
        ce = 1'b1;
        life = 20'h0_0000;
        mismatches = 0;
        checks_done = 0;
        cyc = 0;
        repeat (3) @(negedge clk_sys_i);
        rst_b_i = 1'b1;
        `CHK(cmd.op, pibc_pkg::OP_LOAD)
        wait_idle();
        `CHK(acks, 16'd663)
        rd(16'h0000, d);
        `CHK(d, pibc_pkg::RD_UNMAPPED)
        slow = 1'b1;
        a0 = acks;
        wr(pibc_pkg::ADDR_INIT_REQ, pibc_pkg::REQ_ON);
        @(negedge clk_sys_i);
        `CHK(cmd.op, pibc_pkg::OP_DEFAULT)
        wr(pibc_pkg::ADDR_INIT_REQ, pibc_pkg::REQ_OFF);
        rd(pibc_pkg::ADDR_INIT_REQ, d);
        `CHK(d, pibc_pkg::REQ_ON)
        wait_idle();
        rd(pibc_pkg::ADDR_INIT_REQ, d);
        `CHK(d, pibc_pkg::REQ_OFF)
        `CHK(acks - a0, 16'd663)
        host_rdy = 1'b1;
        wr(pibc_pkg::ADDR_INIT_REQ, pibc_pkg::REQ_ON);
        repeat (2) @(negedge clk_sys_i);
        `CHK(warn, pibc_pkg::WARN_HOST_READY)
        `CHK(busy, 1'b0)
        pulse_clear();
        `CHK(warn, pibc_pkg::CODE_NONE)
        ce = 1'b0;
        wr(pibc_pkg::ADDR_SAVE_REQ, pibc_pkg::REQ_ON);
        ce = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        `CHK(busy, 1'b0)
        rd(pibc_pkg::ADDR_SAVE_REQ, d);
        `CHK(d, pibc_pkg::REQ_OFF)
        {host_rdy, slow} = 2'b00;
        a0 = acks;
        wr(pibc_pkg::ADDR_SAVE_REQ, pibc_pkg::REQ_ON);
        wait_idle();
        rd(pibc_pkg::ADDR_SAVE_REQ, d);
        `CHK(d, pibc_pkg::REQ_OFF)
        `CHK(acks - a0, 16'd663)
        `CHK(last_op, pibc_pkg::OP_BACKUP)
        `CHK(cnt, 5'h01)
        fail = 1'b1;
        life = pibc_pkg::LIFE_MAX + 20'h0_0001;
        wr(pibc_pkg::ADDR_SAVE_REQ, pibc_pkg::REQ_ON);
        wait_idle();
        `CHK(err, pibc_pkg::ERR_FLASH_WRITE)
        pulse_clear();
        life = pibc_pkg::LIFE_MAX;
        for (int i = 2; i < 25; i++) begin
            wr(pibc_pkg::ADDR_SAVE_REQ, pibc_pkg::REQ_ON);
            wait_idle();
            `CHK(err, pibc_pkg::CODE_NONE)
        end
        `CHK(cnt, pibc_pkg::SESSION_MAX)
        wr(pibc_pkg::ADDR_SAVE_REQ, pibc_pkg::REQ_ON);
        repeat (2) @(negedge clk_sys_i);
        `CHK(err, pibc_pkg::ERR_WRITE_NUM)
        pulse_clear();
        `CHK(err, pibc_pkg::ERR_WRITE_NUM)
        life = pibc_pkg::LIFE_MAX + 20'h0_0001;
        wr(pibc_pkg::ADDR_INIT_REQ, pibc_pkg::REQ_ON);
        wait_idle();
        `CHK(err, pibc_pkg::ERR_WRITE_NUM)
        rst_b_i = 1'b0;
        @(negedge clk_sys_i);
        rst_b_i = 1'b1;
        wait_idle();
        `CHK(err, pibc_pkg::CODE_NONE)
        `CHK(cnt, pibc_pkg::SESSION_RST)
        final_report();
    end
endmodule : tb_param_init_and_backup_ctrl
bind pibc_ctrl pibc_ctrl_chk u_chk (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .ce_i(ce_i), .bm_req_i(bm_req_i),
    .host_ready_output_i(host_ready_output_i), .mem_req_o(mem_req_o),
    .mem_cmd_o(mem_cmd_o), .mem_ack_i(mem_ack_i), .mem_fail_i(mem_fail_i),
    .flash_life_count_i(flash_life_count_i), .busy_o(busy_o),
    .err_code_o(err_code_o), .warn_code_o(warn_code_o),
    .flash_write_count_monitor_o(flash_write_count_monitor_o));
`default_nettype wire
